// *** shared/mtp_params.svh ***
// register codes, field positions, masks and reset values for the mmu support unit
`ifndef MTP_PARAMS_SVH
`define MTP_PARAMS_SVH

// register select codes carried on the slave instruction port
`define MTP_SEL_TABLE0   3'h0
`define MTP_SEL_TABLE1   3'h1
`define MTP_SEL_FAULT    3'h2
`define MTP_SEL_WATCH0   3'h3
`define MTP_SEL_WATCH1   3'h4
`define MTP_SEL_SKIP     3'h5

// table base alignment: low ten bits always zero
`define MTP_TABLE_MASK   32'hfffffc00

// watch point fields
`define MTP_WP_SPACE     31
`define MTP_WP_PHYS      30
`define MTP_WP_EXEC      29
`define MTP_WP_READ      28
`define MTP_WP_WRITE     27
`define MTP_WP_GATE      26
`define MTP_WP_COND_HI   30
`define MTP_WP_COND_LO   26
`define MTP_WP_MASK0     32'hfcffffff
`define MTP_WP_MASK1     32'hf8ffffff

// address field width and the fault register space bit
`define MTP_ADDR_W       24
`define MTP_FAULT_SPACE  31

// cycle type status codes of the cpu status bus
`define MTP_ST_SEQ_FETCH 3'h0
`define MTP_ST_NSQ_FETCH 3'h1
`define MTP_ST_OPERAND   3'h2
`define MTP_ST_RMW_READ  3'h3
`define MTP_ST_EA_READ   3'h4

// reset values
`define MTP_RST_WORD     32'h00000000
`define MTP_RST_COUNT    24'h000000

`endif

// *** shared/mtp_pkg.sv ***
// types shared by the mmu support unit and its bench
package mtp_pkg;

   // one observed cpu memory access
   typedef struct packed {
      logic [23:0] vaddr;
      logic        vspace;
      logic [23:0] paddr;
      logic        mem_sys;
      logic        is_read;
      logic [2:0]  status;
   } mtp_access_t;

   // one slave load or store instruction
   typedef struct packed {
      logic        valid;
      logic        is_load;
      logic [2:0]  sel;
      logic [31:0] wdata;
   } mtp_cmd_t;

   // purge request to the translation buffer
   typedef struct packed {
      logic        one_valid;
      logic [23:0] one_addr;
      logic        one_space;
      logic        all_valid;
      logic        all_space;
   } mtp_purge_t;

endpackage : mtp_pkg

// *** design/mtp_unit.sv ***
// mmu support registers: table bases, fault/purge address and breakpoint logic
//
// Summary of operation
// - table base registers always hold zero in their ten lowest bits
// - table bases are written by load and read by store slave instructions
// - reading fault register returns virtual address of latest translation error
// - writing fault register purges matching buffer entry, else nothing happens
// - translation error captures faulting address and its space bit
// - purge uses low 24 address bits and requires address and space match
// - loading a table base purges all entries of its address space
// - clearing translate enables leaves buffer entries untouched
// - watch point registers are 32 bits, implemented bits read and write
// - match address is bits 0 to 23 plus space bit 31
// - bits 24,25 absent; gate bit 26 exists only in watch point zero
// - watch point with condition bits 26 to 30 all zero never breaks
// - space bit compares address space when virtual, memory system bit when physical
// - physical select 0 compares virtual addresses, 1 compares translated addresses
// - execute break fires before instruction at its first byte address
// - read trigger breaks on data reads, never on instruction fetches
// - write trigger breaks on data writes and read phase of rmw
// - with gating on, met condition traps only when counter is zero
// - with gating on and counter nonzero, no trap, counter decrements
// - with gating off, watch point zero traps at once, counter untouched
// - skip counter is 32 bits with counter in low 24 bits
// - comparators active only with global enable; cleared by reset, trap, error
// - break pulses interrupt when action select 0, abort when 1
// - record triggering watch point; second one when both trigger together
`timescale 1ns/1ns
`include "mtp_params.svh"

module mtp_unit
   import mtp_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // slave instruction port
   input  wire mtp_cmd_t    cmd,
   output logic [31:0]      rdata,
   output logic             rvalid,
   // observed cpu accesses
   input  wire logic        acc_valid,
   input  wire mtp_access_t acc,
   // translation error report from the walker
   input  wire logic        xlat_err,
   input  wire logic [23:0] xlat_err_addr,
   input  wire logic        xlat_err_space,
   // status and control bits held in the status register
   input  wire logic        brk_enable_load,
   input  wire logic        brk_enable_value,
   input  wire logic        trap_action_select,
   // translation buffer purge requests
   output mtp_purge_t       purge,
   // break outputs
   output logic             int_pulse,
   output logic             abort_pulse,
   output logic             breakpoint_global_enable,
   output logic             last_trigger_index,
   // table base values for the walker
   output logic [31:0]      space0_table_base,
   output logic [31:0]      space1_table_base
);

   // registers
   logic [31:0] space0_table_base_reg;
   logic [31:0] space1_table_base_reg;
   logic [31:0] fault_or_purge_address_reg;
   logic [31:0] watch_point_zero_reg;
   logic [31:0] watch_point_one_reg;
   logic [23:0] watch_skip_counter_reg;
   logic        brk_en_reg;
   logic        last_idx_reg;
   logic        int_reg;
   logic        abort_reg;
   logic [31:0] rdata_reg;
   logic        rvalid_reg;
   mtp_purge_t  purge_reg;

   // decoded strobes
   logic        wr_en;
   logic        rd_en;
   logic        hit0;
   logic        hit1;
   logic        gate_on;
   logic        count_zero;
   logic        trig0;
   logic        trig1;
   logic        trap;
   logic [31:0] rdata_next;

   // address and condition match for one watch point
   function automatic logic wp_match(input logic [31:0] wp, input mtp_access_t a);
      logic [23:0] cmp_addr;
      logic        cmp_space;
      logic        addr_hit;
      logic        fetch;
      logic        data_rd;
      logic        data_wr;
      logic        rmw_rd;
      cmp_addr  = wp[`MTP_WP_PHYS] ? a.paddr : a.vaddr;
      cmp_space = wp[`MTP_WP_PHYS] ? a.mem_sys : a.vspace;
      addr_hit  = (cmp_addr == wp[`MTP_ADDR_W-1:0]) && (cmp_space == wp[`MTP_WP_SPACE]);
      fetch     = a.is_read && ((a.status == `MTP_ST_SEQ_FETCH) ||
                                (a.status == `MTP_ST_NSQ_FETCH));
      data_rd   = a.is_read && ((a.status == `MTP_ST_OPERAND) ||
                                (a.status == `MTP_ST_EA_READ));
      data_wr   = !a.is_read && (a.status == `MTP_ST_OPERAND);
      rmw_rd    = a.is_read && (a.status == `MTP_ST_RMW_READ);
      // a zero condition field leaves every term below false
      wp_match  = addr_hit &&
                  ((wp[`MTP_WP_EXEC] && fetch) ||
                   (wp[`MTP_WP_READ] && data_rd) ||
                   (wp[`MTP_WP_WRITE] && (data_wr || rmw_rd)));
   endfunction : wp_match

   // slave instruction decode
   assign wr_en = cmd.valid && cmd.is_load;
   assign rd_en = cmd.valid && !cmd.is_load;

   // comparators see one access at a time and only while enabled
   assign hit0 = brk_en_reg && acc_valid && wp_match(watch_point_zero_reg, acc);
   assign hit1 = brk_en_reg && acc_valid && wp_match(watch_point_one_reg, acc);

   // skip counter gating applies to watch point zero only
   assign gate_on    = watch_point_zero_reg[`MTP_WP_GATE];
   assign count_zero = (watch_skip_counter_reg == `MTP_RST_COUNT);
   assign trig0      = hit0 && (!gate_on || count_zero);
   assign trig1      = hit1;
   assign trap       = trig0 || trig1;

   // table base registers, low bits forced to zero on every load
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         space0_table_base_reg <= `MTP_RST_WORD;
         space1_table_base_reg <= `MTP_RST_WORD;
      end else if (wr_en) begin
         if (cmd.sel == `MTP_SEL_TABLE0) begin
            space0_table_base_reg <= cmd.wdata & `MTP_TABLE_MASK;
         end
         if (cmd.sel == `MTP_SEL_TABLE1) begin
            space1_table_base_reg <= cmd.wdata & `MTP_TABLE_MASK;
         end
      end
   end

   // fault address capture; a software write in the same cycle loses to the error
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_or_purge_address_reg <= `MTP_RST_WORD;
      end else if (xlat_err) begin
         fault_or_purge_address_reg <= {xlat_err_space, 7'h00, xlat_err_addr};
      end else if (wr_en && (cmd.sel == `MTP_SEL_FAULT)) begin
         fault_or_purge_address_reg <= {cmd.wdata[`MTP_FAULT_SPACE], 7'h00,
                                         cmd.wdata[`MTP_ADDR_W-1:0]};
      end
   end

   // purge requests: one cycle pulses toward the translation buffer
   // translate enables are not looked at here, so turning them off purges nothing
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         purge_reg <= '0;
      end else begin
         purge_reg.one_valid <= wr_en && (cmd.sel == `MTP_SEL_FAULT);
         purge_reg.one_addr  <= cmd.wdata[`MTP_ADDR_W-1:0];
         purge_reg.one_space <= cmd.wdata[`MTP_FAULT_SPACE];
         purge_reg.all_valid <= wr_en && ((cmd.sel == `MTP_SEL_TABLE0) ||
                                          (cmd.sel == `MTP_SEL_TABLE1));
         purge_reg.all_space <= (cmd.sel == `MTP_SEL_TABLE1);
      end
   end

   // watch point registers keep only their implemented bits
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         watch_point_zero_reg <= `MTP_RST_WORD;
         watch_point_one_reg  <= `MTP_RST_WORD;
      end else if (wr_en) begin
         if (cmd.sel == `MTP_SEL_WATCH0) begin
            watch_point_zero_reg <= cmd.wdata & `MTP_WP_MASK0;
         end
         if (cmd.sel == `MTP_SEL_WATCH1) begin
            watch_point_one_reg <= cmd.wdata & `MTP_WP_MASK1;
         end
      end
   end

   // skip counter; a software load takes priority over a decrement
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         watch_skip_counter_reg <= `MTP_RST_COUNT;
      end else if (wr_en && (cmd.sel == `MTP_SEL_SKIP)) begin
         watch_skip_counter_reg <= cmd.wdata[`MTP_ADDR_W-1:0];
      end else if (hit0 && gate_on && !count_zero) begin
         watch_skip_counter_reg <= watch_skip_counter_reg - 24'h000001;
      end
   end

   // global enable: cleared on any trap or error, which win over a load
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         brk_en_reg <= 1'b0;
      end else if (trap || xlat_err) begin
         brk_en_reg <= 1'b0;
      end else if (brk_enable_load) begin
         brk_en_reg <= brk_enable_value;
      end
   end

   // trap index and action pulses
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_idx_reg <= 1'b0;
         int_reg      <= 1'b0;
         abort_reg    <= 1'b0;
      end else begin
         if (trap) begin
            last_idx_reg <= trig1;
         end
         int_reg   <= trap && !trap_action_select;
         abort_reg <= trap && trap_action_select;
      end
   end

   // store instruction readback mux
   always_comb begin
      case (cmd.sel)
         `MTP_SEL_TABLE0: rdata_next = space0_table_base_reg;
         `MTP_SEL_TABLE1: rdata_next = space1_table_base_reg;
         `MTP_SEL_FAULT:  rdata_next = fault_or_purge_address_reg;
         `MTP_SEL_WATCH0: rdata_next = watch_point_zero_reg;
         `MTP_SEL_WATCH1: rdata_next = watch_point_one_reg;
         `MTP_SEL_SKIP:   rdata_next = {8'h00, watch_skip_counter_reg};
         default:         rdata_next = `MTP_RST_WORD;
      endcase
   end

   // read data is registered so the port comes from a flip-flop
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_reg  <= `MTP_RST_WORD;
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= rd_en;
         if (rd_en) begin
            rdata_reg <= rdata_next;
         end
      end
   end

   // outputs
   assign rdata                    = rdata_reg;
   assign rvalid                   = rvalid_reg;
   assign purge                    = purge_reg;
   assign int_pulse                = int_reg;
   assign abort_pulse              = abort_reg;
   assign breakpoint_global_enable = brk_en_reg;
   assign last_trigger_index       = last_idx_reg;
   assign space0_table_base        = space0_table_base_reg;
   assign space1_table_base        = space1_table_base_reg;

endmodule : mtp_unit

// *** tb/mtp_unit_assertions.sv ***
// port checks for the mmu support unit
`timescale 1ns/1ns
`include "mtp_params.svh"
module mtp_unit_chk
   import mtp_pkg::*;
(
   // clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // watched inputs
   input wire mtp_cmd_t    cmd,
   input wire logic        xlat_err,
   input wire logic        trap_action_select,
   // watched outputs
   input wire logic        rvalid,
   input wire mtp_purge_t  purge,
   input wire logic        int_pulse,
   input wire logic        abort_pulse,
   input wire logic        breakpoint_global_enable,
   input wire logic [31:0] space0_table_base,
   input wire logic [31:0] space1_table_base
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   // table base alignment, slave port answers and purge requests
   chk_base_align: assert property (
      (space0_table_base[9:0] | space1_table_base[9:0]) == 10'h000)
      else $error("table base not aligned");
   chk_store_answer: assert property (cmd.valid && !cmd.is_load |=> rvalid)
      else $error("store got no answer");
   chk_purge_one: assert property (cmd.valid && cmd.is_load && cmd.sel == `MTP_SEL_FAULT
      |=> purge.one_valid && purge.one_addr == $past(cmd.wdata[23:0])
      && purge.one_space == $past(cmd.wdata[31])) else $error("purge request wrong");
   chk_purge_all: assert property (cmd.valid && cmd.is_load && cmd.sel[2:1] == 2'b00
      |=> purge.all_valid && purge.all_space == $past(cmd.sel[0]))
      else $error("table load did not purge its space");
   // break gating and action; a trap must also disarm
   chk_gate_off: assert property (!breakpoint_global_enable
      |=> !int_pulse && !abort_pulse) else $error("break while disabled");
   chk_action_sel: assert property (int_pulse || abort_pulse
      |-> int_pulse != abort_pulse && abort_pulse == $past(trap_action_select))
      else $error("wrong break action");
   chk_trap_clears: assert property (int_pulse || abort_pulse
      |-> !breakpoint_global_enable) else $error("enable kept after trap");
   chk_err_clears: assert property (xlat_err |=> !breakpoint_global_enable)
      else $error("enable kept after error");
endmodule : mtp_unit_chk

bind mtp_unit mtp_unit_chk mtp_unit_chk_i (.clk(clk), .rst_n(rst_n), .cmd(cmd),
   .xlat_err(xlat_err), .trap_action_select(trap_action_select), .rvalid(rvalid),
   .purge(purge), .int_pulse(int_pulse), .abort_pulse(abort_pulse),
   .breakpoint_global_enable(breakpoint_global_enable),
   .space0_table_base(space0_table_base), .space1_table_base(space1_table_base));

// *** tb/mtp_host.sv ***
// host cpu model: slave register instructions, memory accesses, walker errors
`timescale 1ns/1ns
module mtp_host
   import mtp_pkg::*;
(
   // clock
   input wire logic        clk,
   // slave instruction port
   output mtp_cmd_t        cmd,
   input wire logic [31:0] rdata,
   input wire logic        rvalid,
   // accesses and errors
   output mtp_access_t     acc,
   output logic            acc_valid,
   output logic            xlat_err,
   output logic [23:0]     xlat_err_addr,
   output logic            xlat_err_space
);
   // idle lines at time zero
   initial begin
      cmd = '0;
      acc = '0;
      acc_valid = 1'b0;
      xlat_err = 1'b0;
      xlat_err_addr = 24'h0;
      xlat_err_space = 1'b0;
   end

   // one load or store; released data shows the inverse, not stale bits
   task automatic xfer(input logic ld, input logic [2:0] sel, input logic [31:0] wd,
                       output logic [31:0] rd, input int slow);
      repeat (slow) @(posedge clk);
      @(posedge clk);
      #1;
      cmd = '{1'b1, ld, sel, wd};
      @(posedge clk);
      #1;
      cmd.valid = 1'b0;
      cmd.wdata = ~wd;
      rd = (rvalid === 1'b1) ? rdata : 32'hxxxxxxxx;
   endtask : xfer

   // one access; physical side carries inverted address so modes differ
   task automatic access(input logic [23:0] a, input logic sp, input logic r,
                         input logic [2:0] st);
      @(posedge clk);
      #1;
      acc_valid = 1'b1;
      acc = '{a, sp, ~a, ~sp, r, st};
      @(posedge clk);
      #1;
      acc_valid = 1'b0;
      acc = ~acc;
   endtask : access

   // walker error pulse
   task automatic err(input logic [23:0] a, input logic sp);
      @(posedge clk);
      #1;
      xlat_err = 1'b1;
      xlat_err_addr = a;
      xlat_err_space = sp;
      @(posedge clk);
      #1;
      xlat_err = 1'b0;
      xlat_err_addr = ~a;
   endtask : err
endmodule : mtp_host

// *** tb/mtp_unit_tb.sv ***
// self-checking bench for the mmu support unit
`timescale 1ns/1ns
`include "mtp_params.svh"
module mtp_unit_tb
   import mtp_pkg::*;
;
   // bench signals
   logic        clk = 1'b0, rst_n = 1'b0, en_ld = 1'b0, en_val = 1'b1, act_sel = 1'b0;
   logic        rvalid, acc_valid, xlat_err, xe_sp, int_p, abort_p, gen, idx;
   logic [31:0] rdata, rd, s0, s1;
   logic [23:0] xe_addr;
   mtp_cmd_t    cmd;
   mtp_access_t acc;
   mtp_purge_t  purge;
   int          failures = 0, total_checks = 0, cycles = 0;

   always #5 clk = ~clk;

   // unit and host model
   mtp_unit mtp_unit_i (.clk(clk), .rst_n(rst_n), .cmd(cmd), .rdata(rdata), .rvalid(rvalid),
      .acc_valid(acc_valid), .acc(acc), .xlat_err(xlat_err), .xlat_err_addr(xe_addr),
      .xlat_err_space(xe_sp), .brk_enable_load(en_ld), .brk_enable_value(en_val),
      .trap_action_select(act_sel), .purge(purge), .int_pulse(int_p), .abort_pulse(abort_p),
      .breakpoint_global_enable(gen), .last_trigger_index(idx), .space0_table_base(s0),
      .space1_table_base(s1));
   mtp_host mtp_host_i (.clk(clk), .cmd(cmd), .rdata(rdata), .rvalid(rvalid), .acc(acc),
      .acc_valid(acc_valid), .xlat_err(xlat_err), .xlat_err_addr(xe_addr),
      .xlat_err_space(xe_sp));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic rdc(input logic [2:0] sel, input logic [31:0] exp);
      mtp_host_i.xfer(1'b0, sel, 32'h0, rd, 1);
      chk(rd, exp);
   endtask : rdc

   // load the global enable from en_val with one pulse; en_val idles high
   task automatic arm();
      @(posedge clk);
      #1;
      en_ld = 1'b1;
      @(posedge clk);
      #1;
      en_ld = 1'b0;
   endtask : arm

   // access, then judge {int, abort, enable, index}
   task automatic hit(input logic [23:0] a, input logic sp, input logic r, input logic [2:0] st,
                      input logic [3:0] e);
      mtp_host_i.access(a, sp, r, st);
      chk({28'h0, int_p, abort_p, gen, idx}, {28'h0, e});
   endtask : hit

   task automatic t_regs();
      logic [2:0]  sel [6] = '{`MTP_SEL_TABLE0, `MTP_SEL_TABLE1, `MTP_SEL_WATCH0,
                               `MTP_SEL_WATCH1, `MTP_SEL_SKIP, 3'h7};
      logic [31:0] msk [6] = '{`MTP_TABLE_MASK, `MTP_TABLE_MASK, `MTP_WP_MASK0,
                               `MTP_WP_MASK1, 32'h00ffffff, 32'h0};
      for (int i = 0; i < 6; i++) begin
         mtp_host_i.xfer(1'b1, sel[i], 32'hffffffff, rd, i % 2);
         rdc(sel[i], msk[i]);
      end
      chk(s0, `MTP_TABLE_MASK);
      chk(s1, `MTP_TABLE_MASK);
      $display("test regs done");
   endtask : t_regs

   task automatic t_fault();
      arm();
      mtp_host_i.err(24'habcdef, 1'b1);
      chk({31'h0, gen}, 32'h0);
      rdc(`MTP_SEL_FAULT, 32'h80abcdef);
      mtp_host_i.xfer(1'b1, `MTP_SEL_FAULT, 32'h00123456, rd, 0);
      chk({6'h0, purge.one_valid, purge.one_space, purge.one_addr}, 32'h02123456);
      $display("test fault done");
   endtask : t_fault

   task automatic t_break();
      mtp_host_i.xfer(1'b1, `MTP_SEL_WATCH0, 32'h00000100, rd, 0);
      mtp_host_i.xfer(1'b1, `MTP_SEL_WATCH1, 32'h10000100, rd, 0);
      arm();
      hit(24'h000100, 1'b0, 1'b1, `MTP_ST_SEQ_FETCH, 4'b0010);
      hit(24'h000100, 1'b1, 1'b1, `MTP_ST_OPERAND, 4'b0010);
      hit(24'h000100, 1'b0, 1'b1, `MTP_ST_OPERAND, 4'b1001);
      hit(24'h000100, 1'b0, 1'b1, `MTP_ST_OPERAND, 4'b0001);
      act_sel = 1'b1;
      mtp_host_i.xfer(1'b1, `MTP_SEL_WATCH1, 32'h08000100, rd, 0);
      arm();
      hit(24'h000100, 1'b0, 1'b1, `MTP_ST_RMW_READ, 4'b0101);
      act_sel = 1'b0;
      mtp_host_i.xfer(1'b1, `MTP_SEL_WATCH1, 32'h20000200, rd, 0);
      arm();
      hit(24'h000200, 1'b0, 1'b1, `MTP_ST_NSQ_FETCH, 4'b1001);
      mtp_host_i.xfer(1'b1, `MTP_SEL_WATCH0, 32'hc8000200, rd, 0);
      arm();
      hit(24'hfffdff, 1'b0, 1'b0, `MTP_ST_OPERAND, 4'b1000);
      mtp_host_i.xfer(1'b1, `MTP_SEL_WATCH0, 32'h10000300, rd, 0);
      mtp_host_i.xfer(1'b1, `MTP_SEL_WATCH1, 32'h10000300, rd, 0);
      arm();
      hit(24'h000300, 1'b0, 1'b1, `MTP_ST_OPERAND, 4'b1001);
      $display("test break done");
   endtask : t_break

   task automatic t_count();
      mtp_host_i.xfer(1'b1, `MTP_SEL_WATCH1, 32'h00000000, rd, 0);
      mtp_host_i.xfer(1'b1, `MTP_SEL_WATCH0, 32'h14000400, rd, 0);
      mtp_host_i.xfer(1'b1, `MTP_SEL_SKIP, 32'h00000002, rd, 0);
      arm();
      repeat (2) hit(24'h000400, 1'b0, 1'b1, `MTP_ST_EA_READ, 4'b0011);
      rdc(`MTP_SEL_SKIP, 32'h00000000);
      hit(24'h000400, 1'b0, 1'b1, `MTP_ST_EA_READ, 4'b1000);
      mtp_host_i.xfer(1'b1, `MTP_SEL_WATCH0, 32'h10000400, rd, 0);
      mtp_host_i.xfer(1'b1, `MTP_SEL_SKIP, 32'h00000005, rd, 0);
      arm();
      hit(24'h000400, 1'b0, 1'b1, `MTP_ST_EA_READ, 4'b1000);
      rdc(`MTP_SEL_SKIP, 32'h00000005);
      // a software load of zero must disarm, so a matching access stays silent
      arm();
      en_val = 1'b0;
      arm();
      hit(24'h000400, 1'b0, 1'b1, `MTP_ST_EA_READ, 4'b0000);
      en_val = 1'b1;
      $display("test count done");
   endtask : t_count

   task automatic end_of_test();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test

   // hang guard, far above the roughly 120 cycles needed
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         failures++;
         end_of_test();
      end
   end

   // reset for five cycles, then the tests
   initial begin
      repeat (5) @(posedge clk);
      #1;
      rst_n = 1'b1;
      t_regs();
      t_fault();
      t_break();
      t_count();
      end_of_test();
   end
endmodule : mtp_unit_tb
